// ---- brc_consts.svh ----
// Offsets, field positions, startup values and timing for the regulator register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// Register offsets
`define BRC_OFS_FAULT      8'h00
`define BRC_OFS_VSEL       8'h01
`define BRC_OFS_FIRST_CONTROL_REGISTER      8'h02
`define BRC_OFS_IDENT      8'h03
`define BRC_OFS_SECOND_CONTROL_REGISTER      8'h04

// Field positions
`define BRC_BIT_OVERCUR    2
`define BRC_BIT_OVERTEMP   1
`define BRC_BIT_FBUV       0
`define BRC_BIT_ENABLE     7
`define BRC_BIT_PGDELAY    4
`define BRC_BIT_PSAVE      0
`define BRC_BIT_GO         5
`define BRC_BIT_DISCHARGE  4
`define BRC_BIT_POWER_GOOD_STATUS       3
`define BRC_SLEW_HI        2
`define BRC_SLEW_LO        1

// Startup values and writable masks
`define BRC_RST_ENABLE     1'b1
`define BRC_RST_FIRST_CONTROL_REGISTER      8'h2F
`define BRC_RST_SECOND_CONTROL_REGISTER      8'h02
`define BRC_MASK_FIRST_CONTROL_REGISTER     8'h3F
`define BRC_MASK_SECOND_CONTROL_REGISTER     8'h36
`define BRC_MASK_FAULT     8'h07

// Slave address upper five bits
`define BRC_ADDR_PREFIX    5'h1C

// Power-good delay: time in ms and clock rate in MHz
`define BRC_PG_DELAY_MS    45
`define BRC_CLK_MHZ        200

`endif

// ---- brc_pkg.sv ----
// Types shared by the regulator register bank.
// Assumes brc_consts.svh is on the include path.
`include "brc_consts.svh"

package brc_pkg;

   typedef enum logic [2:0] {
      BRC_IDLE  = 3'b000,
      BRC_ADDR  = 3'b001,
      BRC_REG   = 3'b010,
      BRC_WDATA = 3'b011,
      BRC_RDATA = 3'b100,
      BRC_SKIP  = 3'b101
   } brc_state_t;

   typedef struct packed {
      logic overcur;
      logic overtemp;
      logic fbuv;
   } brc_fault_t;

   typedef struct packed {
      logic       regulator_enable;
      logic [6:0] ref_target_code;
      logic       power_good_delay_select;
      logic       pulse_skip_power_saving;
      logic       discharge_enable;
      logic [1:0] slew_select;
   } brc_ctrl_t;

endpackage

// ---- brc_bank.sv ----
// Register bank of a step-down regulator, reached as a two-wire serial slave.
// Assumes scl/sda come from the bus pins and analog status lines are asynchronous.
`timescale 1ns/1ps
`include "brc_consts.svh"

// What this block does
// - Over-current flag at bit 2 latches, held until host writes one there
// - Over-temperature flag at bit 1 latches, cleared only by writing one
// - Feedback undervoltage flag at bit 0 latches, cleared only by writing one
// - Offset 01h bit 7 enables regulator; enabled after startup
// - Offset 01h bits 6:0 are the reference DAC code
// - Startup reference code is a per-variant constant
// - First control bit 4 selects 45 ms power-good delay, off at startup
// - First control bit 0: zero forces PWM, one (startup) allows power saving
// - Offset 03h is read-only, bits 7:4 give a maker code
// - Identification bits 3:2 report the variant address bits
// - Identification bits 1:0 encode default output voltage, 11 for 0.95 V
// - Any write to second control bit 5 starts a voltage transition
// - With trigger bit zero the output ramps to the default code
// - Second control bit 4 discharges the output through switch node while disabled
// - Second control bit 3 reads one only when regulating and settled
// - Power-good status reads zero during transitions or out of regulation
// - Second control bits 2:1 select slew, startup code 01
// - Startup defaults apply, first control reserved 7:6 zero, 3:1 one
// - Write data commits to a register only after a valid stop
// - Slave answers address 11100 plus variant bits, last bit direction
module brc_bank #(
   parameter logic [6:0] DEFAULT_CODE    = 7'h00,
   parameter logic [1:0] ADDR_BITS       = 2'b00,
   parameter logic [1:0] OUTPUT_VOLTAGE_VARIANT_CODE       = 2'b11,
   parameter logic [3:0] MAKER_CODE      = 4'h5,
   parameter int         PG_DELAY_CYCLES = `BRC_PG_DELAY_MS * 1000 * `BRC_CLK_MHZ
) (
   // System clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Serial bus pins
   input  wire logic              scl,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // Analog status, asynchronous
   input  wire brc_pkg::brc_fault_t fault_event,
   input  wire logic              output_in_regulation,
   input  wire logic              ramp_done,
   // Regulator control
   output brc_pkg::brc_ctrl_t     ctrl,
   output logic                   transition_start,
   output logic                   power_good_output
);

   // Link domain: one bit per rising scl edge, announced by a toggle
   logic link_bit_q = 1'b0;
   logic link_tgl_q = 1'b0;

   always_ff @(posedge scl) begin
      link_bit_q <= sda_in;
      link_tgl_q <= ~link_tgl_q;
   end

   // Crossings into clk domain
   logic [2:0] tgl_s_q;
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   brc_pkg::brc_fault_t fault_s1_q, fault_s2_q;
   logic [1:0] inreg_s_q;
   logic [1:0] done_s_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         tgl_s_q    <= 3'h0;
         scl_s_q    <= 3'h7;
         sda_s_q    <= 3'h7;
         fault_s1_q <= '0;
         fault_s2_q <= '0;
         inreg_s_q  <= 2'h0;
         done_s_q   <= 2'h0;
      end else begin
         tgl_s_q    <= {tgl_s_q[1:0], link_tgl_q};
         scl_s_q    <= {scl_s_q[1:0], scl};
         sda_s_q    <= {sda_s_q[1:0], sda_in};
         fault_s1_q <= fault_event;
         fault_s2_q <= fault_s1_q;
         inreg_s_q  <= {inreg_s_q[0], output_in_regulation};
         done_s_q   <= {done_s_q[0], ramp_done};
      end
   end

   // Bit stays stable until the next scl edge, long after the toggle lands
   logic bit_ev, fall_ev, start_ev, stop_ev;
   assign bit_ev   = tgl_s_q[2] ^ tgl_s_q[1];
   assign fall_ev  = scl_s_q[2] & ~scl_s_q[1];
   assign start_ev = scl_s_q[2] & scl_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
   assign stop_ev  = scl_s_q[2] & scl_s_q[1] & ~sda_s_q[2] & sda_s_q[1];

   // Register storage
   brc_pkg::brc_fault_t flags_q;
   logic       en_q;
   logic [6:0] code_q;
   logic [7:0] first_control_register_q;
   logic [7:0] second_control_register_q;
   logic       power_good_status_q;
   logic       busy_q;

   function automatic logic [7:0] brc_read(input logic [7:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      if (ofs == `BRC_OFS_FAULT) begin
         v = {5'h00, flags_q};
      end else if (ofs == `BRC_OFS_VSEL) begin
         v = {en_q, code_q};
      end else if (ofs == `BRC_OFS_FIRST_CONTROL_REGISTER) begin
         v = first_control_register_q & `BRC_MASK_FIRST_CONTROL_REGISTER;
      end else if (ofs == `BRC_OFS_IDENT) begin
         v = {MAKER_CODE, ADDR_BITS, OUTPUT_VOLTAGE_VARIANT_CODE};
      end else if (ofs == `BRC_OFS_SECOND_CONTROL_REGISTER) begin
         v = (second_control_register_q & `BRC_MASK_SECOND_CONTROL_REGISTER) | ({7'h00, power_good_status_q} << `BRC_BIT_POWER_GOOD_STATUS);
      end
      return v;
   endfunction

   // Protocol engine
   brc_pkg::brc_state_t state_q;
   logic [3:0] bit_q;
   logic [6:0] rx_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic       ack_q;
   logic       pend_q;
   logic [7:0] pw_addr_q;
   logic [7:0] pw_data_q;
   logic [7:0] byte_in;
   logic       addr_hit;

   assign byte_in  = {rx_q, link_bit_q};
   assign addr_hit = byte_in[7:1] == {`BRC_ADDR_PREFIX, ADDR_BITS};

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q   <= brc_pkg::BRC_IDLE;
         bit_q     <= 4'h0;
         rx_q      <= 7'h00;
         tx_q      <= 8'h00;
         ptr_q     <= 8'h00;
         ack_q     <= 1'b0;
         pend_q    <= 1'b0;
         pw_addr_q <= 8'h00;
         pw_data_q <= 8'h00;
      end else if (start_ev) begin
         state_q <= brc_pkg::BRC_ADDR;
         bit_q   <= 4'h0;
         ack_q   <= 1'b0;
      end else if (stop_ev) begin
         state_q <= brc_pkg::BRC_IDLE;
         bit_q   <= 4'h0;
         ack_q   <= 1'b0;
         pend_q  <= 1'b0;
      end else if (bit_ev && state_q != brc_pkg::BRC_IDLE) begin
         if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            // The address ack is ours; only a byte the host acks moves the pointer
            if (state_q == brc_pkg::BRC_RDATA && !ack_q) begin
               if (link_bit_q) begin
                  state_q <= brc_pkg::BRC_SKIP;
               end else begin
                  ptr_q <= ptr_q + 8'h01;
                  tx_q  <= brc_read(ptr_q + 8'h01);
               end
            end
         end else begin
            rx_q  <= byte_in[6:0];
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
               case (state_q)
                  brc_pkg::BRC_ADDR: begin
                     if (addr_hit) begin
                        ack_q   <= 1'b1;
                        tx_q    <= brc_read(ptr_q);
                        state_q <= byte_in[0] ? brc_pkg::BRC_RDATA : brc_pkg::BRC_REG;
                     end else begin
                        state_q <= brc_pkg::BRC_SKIP;
                     end
                  end
                  brc_pkg::BRC_REG: begin
                     ack_q   <= 1'b1;
                     ptr_q   <= byte_in;
                     state_q <= brc_pkg::BRC_WDATA;
                  end
                  brc_pkg::BRC_WDATA: begin
                     // One byte per frame; more bytes are refused
                     if (!pend_q) begin
                        ack_q     <= 1'b1;
                        pend_q    <= 1'b1;
                        pw_addr_q <= ptr_q;
                        pw_data_q <= byte_in;
                     end else begin
                        state_q <= brc_pkg::BRC_SKIP;
                     end
                  end
                  default: begin
                     ack_q <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // Open-drain drive is set after scl has fallen; reset, start and stop release it
   always_ff @(posedge clk) begin
      if (rst || start_ev || stop_ev) begin
         sda_oe <= 1'b0;
      end else if (fall_ev) begin
         if (bit_q == 4'h8) begin
            sda_oe <= ack_q;
         end else if (state_q == brc_pkg::BRC_RDATA) begin
            sda_oe <= ~tx_q[3'h7 - bit_q[2:0]];
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end
   assign sda_out = 1'b0;

   // Commit happens only at stop
   logic commit;
   assign commit = stop_ev & pend_q;

   logic wr_fault, wr_vsel, wr_first_control_register, wr_second_control_register;
   assign wr_fault = commit && pw_addr_q == `BRC_OFS_FAULT;
   assign wr_vsel  = commit && pw_addr_q == `BRC_OFS_VSEL;
   assign wr_first_control_register = commit && pw_addr_q == `BRC_OFS_FIRST_CONTROL_REGISTER;
   assign wr_second_control_register = commit && pw_addr_q == `BRC_OFS_SECOND_CONTROL_REGISTER;

   // Fault flags: a new event wins over a clearing write
   brc_pkg::brc_fault_t clr;
   assign clr = wr_fault ? brc_pkg::brc_fault_t'(pw_data_q[2:0]) : brc_pkg::brc_fault_t'(3'h0);

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_q <= '0;
      end else begin
         flags_q.overcur  <= fault_s2_q.overcur | (flags_q.overcur & ~clr.overcur);
         flags_q.overtemp <= fault_s2_q.overtemp | (flags_q.overtemp & ~clr.overtemp);
         flags_q.fbuv     <= fault_s2_q.fbuv | (flags_q.fbuv & ~clr.fbuv);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         en_q   <= `BRC_RST_ENABLE;
         code_q <= DEFAULT_CODE;
      end else if (wr_vsel) begin
         en_q   <= pw_data_q[`BRC_BIT_ENABLE];
         code_q <= pw_data_q[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         first_control_register_q <= `BRC_RST_FIRST_CONTROL_REGISTER;
         second_control_register_q <= `BRC_RST_SECOND_CONTROL_REGISTER;
      end else begin
         if (wr_first_control_register) begin
            first_control_register_q <= pw_data_q & `BRC_MASK_FIRST_CONTROL_REGISTER;
         end
         if (wr_second_control_register) begin
            second_control_register_q <= pw_data_q & `BRC_MASK_SECOND_CONTROL_REGISTER;
         end
      end
   end

   // Transition tracking; a new start wins over a late done
   always_ff @(posedge clk) begin
      if (rst) begin
         transition_start <= 1'b0;
         busy_q           <= 1'b0;
         power_good_status_q           <= 1'b0;
      end else begin
         transition_start <= wr_second_control_register;
         busy_q           <= wr_second_control_register | (busy_q & ~done_s_q[1]);
         power_good_status_q           <= inreg_s_q[1] & ~busy_q & ~wr_second_control_register;
      end
   end

   // Power-good pin with optional delay
   logic [31:0] pg_cnt_q;
   always_ff @(posedge clk) begin
      if (rst || !power_good_status_q) begin
         pg_cnt_q          <= 32'h0000_0000;
         power_good_output <= 1'b0;
      end else if (!first_control_register_q[`BRC_BIT_PGDELAY]) begin
         power_good_output <= 1'b1;
      end else if (pg_cnt_q < 32'(PG_DELAY_CYCLES)) begin
         pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
      end else begin
         power_good_output <= 1'b1;
      end
   end

   // Control outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= '0;
      end else begin
         ctrl.regulator_enable        <= en_q;
         ctrl.ref_target_code         <= second_control_register_q[`BRC_BIT_GO] ? code_q : DEFAULT_CODE;
         ctrl.power_good_delay_select <= first_control_register_q[`BRC_BIT_PGDELAY];
         ctrl.pulse_skip_power_saving <= first_control_register_q[`BRC_BIT_PSAVE];
         ctrl.discharge_enable        <= second_control_register_q[`BRC_BIT_DISCHARGE] & ~en_q;
         ctrl.slew_select             <= second_control_register_q[`BRC_SLEW_HI:`BRC_SLEW_LO];
      end
   end

   // Checks
   property p_overcur_hold;
      @(posedge clk) disable iff (rst)
      flags_q.overcur && !clr.overcur |=> flags_q.overcur;
   endproperty
   a_overcur_hold: assert property (p_overcur_hold) else $error("overcur flag lost");

   property p_overtemp_latch;
      @(posedge clk) disable iff (rst)
      fault_s2_q.overtemp |=> flags_q.overtemp;
   endproperty
   a_overtemp_latch: assert property (p_overtemp_latch) else $error("overtemp not latched");

   property p_fbuv_clear;
      @(posedge clk) disable iff (rst)
      $fell(flags_q.fbuv) |-> $past(wr_fault) && $past(pw_data_q[`BRC_BIT_FBUV]);
   endproperty
   a_fbuv_clear: assert property (p_fbuv_clear) else $error("fbuv cleared wrongly");

   sequence s_second_control_register_commit;
      wr_second_control_register;
   endsequence
   sequence s_trans_pulse;
      transition_start ##1 !transition_start;
   endsequence
   property p_go_start;
      @(posedge clk) disable iff (rst)
      s_second_control_register_commit |=> s_trans_pulse;
   endproperty
   a_go_start: assert property (p_go_start) else $error("no transition pulse");

   property p_power_good_status_low;
      @(posedge clk) disable iff (rst)
      transition_start |-> !power_good_status_q ##1 !power_good_status_q;
   endproperty
   a_power_good_status_low: assert property (p_power_good_status_low) else $error("power_good_status high in transition");

   property p_commit_stop;
      @(posedge clk) disable iff (rst)
      $changed(code_q) |-> $past(stop_ev);
   endproperty
   a_commit_stop: assert property (p_commit_stop) else $error("write without stop");

   property p_addr_miss;
      @(posedge clk) disable iff (rst)
      bit_ev && state_q == brc_pkg::BRC_ADDR && bit_q == 4'h7 && !addr_hit
         |=> !ack_q && state_q == brc_pkg::BRC_SKIP;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

   property p_pg_delay;
      @(posedge clk) disable iff (rst)
      $rose(power_good_status_q) && first_control_register_q[`BRC_BIT_PGDELAY] |=> !power_good_output [*8];
   endproperty
   a_pg_delay: assert property (p_pg_delay) else $error("power good not delayed");

   property p_start_enabled;
      @(posedge clk)
      $past(rst) && !rst |-> en_q && first_control_register_q == `BRC_RST_FIRST_CONTROL_REGISTER;
   endproperty
   a_start_enabled: assert property (p_start_enabled) else $error("bad startup value");

endmodule

// ---- brc_host_model.sv ----
// Bus master model for the regulator register bank: frames, bytes and bits.
// Assumes the bench resolves the open-drain data line and returns it as sda_line.
`timescale 1ns/1ps
`include "brc_consts.svh"

module brc_host_model (
   // Bus pins
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_line
);
   logic [1:0] addr_bits = 2'b00;
   logic       acked     = 1'b1;

   // Clock stands high between frames; data moves while clock is low, except at start and stop
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic put_bit(input logic b);
      #10 sda_low = ~b;
      #30 scl = 1'b1;
      #40 scl = 1'b0;
   endtask

   // Released line floats to the pull-up level
   task automatic get_bit(output logic b);
      #10 sda_low = 1'b0;
      #30 scl = 1'b1;
      b = sda_line;
      #40 scl = 1'b0;
   endtask

   task automatic start();
      #10 sda_low = 1'b0;
      #30 scl = 1'b1;
      #20 sda_low = 1'b1;
      #20 scl = 1'b0;
   endtask

   task automatic stop();
      #10 sda_low = 1'b1;
      #30 scl = 1'b1;
      #20 sda_low = 1'b0;
      #40;
   endtask

   task automatic put_byte(input logic [7:0] v);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i]);
      end
      get_bit(b);
      acked = acked & ~b;
   endtask

   // Frame left open so the bench can look before the stop
   task automatic write_frame(input logic [7:0] ofs, input logic [7:0] data);
      acked = 1'b1;
      start();
      put_byte({`BRC_ADDR_PREFIX, addr_bits, 1'b0});
      put_byte(ofs);
      put_byte(data);
   endtask

   task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data);
      write_frame(ofs, data);
      stop();
   endtask

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data);
      acked = 1'b1;
      start();
      put_byte({`BRC_ADDR_PREFIX, addr_bits, 1'b0});
      put_byte(ofs);
      start();
      put_byte({`BRC_ADDR_PREFIX, addr_bits, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         get_bit(data[i]);
      end
      put_bit(1'b1);
      stop();
   endtask
endmodule

// ---- brc_tb.sv ----
// Self-checking bench for the regulator register bank.
// Assumes brc_pkg, brc_bank and brc_host_model are compiled first.
`timescale 1ns/1ps

module testbench;
   localparam logic [6:0] DEF_CODE = 7'h15;
   localparam logic [1:0] ADR_BITS = 2'b10;
   localparam logic [3:0] MAKER    = 4'h9;  // Arbitrary code
   localparam logic [7:0] ID_VAL   = {MAKER, ADR_BITS, 2'b11};

   logic                clk         = 1'b0;
   logic                rst         = 1'b1;
   logic                scl;
   logic                sda_low;
   logic                sda_out;
   logic                sda_oe;
   logic                sda_line;
   brc_pkg::brc_fault_t fault_event = '0;
   logic                in_reg      = 1'b1;
   logic                ramp_done   = 1'b0;
   brc_pkg::brc_ctrl_t  ctrl;
   logic                transition_start;
   logic                pg_out;
   int                  err_count   = 0;
   int                  n_tests     = 0;
   int                  n_cycles    = 0;
   int                  n_pulses    = 0;
   int                  p;

   always #2.5 clk = ~clk;
   // Open drain with pull-up: low while either party pulls
   assign sda_line = ~(sda_oe | sda_low);

   brc_bank #(
      .DEFAULT_CODE    (DEF_CODE),
      .ADDR_BITS       (ADR_BITS),
      .OUTPUT_VOLTAGE_VARIANT_CODE       (2'b11),
      .MAKER_CODE      (MAKER),
      .PG_DELAY_CYCLES (20)
   ) dut (
      .clk                  (clk),
      .rst                  (rst),
      .scl                  (scl),
      .sda_in               (sda_line),
      .sda_out              (sda_out),
      .sda_oe               (sda_oe),
      .fault_event          (fault_event),
      .output_in_regulation (in_reg),
      .ramp_done            (ramp_done),
      .ctrl                 (ctrl),
      .transition_start     (transition_start),
      .power_good_output    (pg_out)
   );

   brc_host_model host (
      .scl      (scl),
      .sda_low  (sda_low),
      .sda_line (sda_line)
   );

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Run is far shorter than this; reaching it means a hang
   always @(posedge clk) begin
      n_cycles <= n_cycles + 1;
      if (transition_start === 1'b1) n_pulses <= n_pulses + 1;
      if (n_cycles == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_reg(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] v;
      host.read_reg(ofs, v);
      check(v, exp);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   initial begin
      wait_clk(3);
      rst = 1'b0;
      host.addr_bits = ADR_BITS;
      wait_clk(5);
      check_reg(8'h00, 8'h00);
      check_reg(8'h01, {1'b1, DEF_CODE});
      check_reg(8'h02, 8'h2f);
      check_reg(8'h03, ID_VAL);
      check_reg(8'h04, 8'h0a);
      check({ctrl.regulator_enable, ctrl.ref_target_code}, {1'b1, DEF_CODE});
      check({3'h0, ctrl.power_good_delay_select, ctrl.pulse_skip_power_saving,
             ctrl.discharge_enable, ctrl.slew_select}, 8'h09);
      check({7'h0, sda_out}, 8'h00);
      $display("test startup done");

      host.write_reg(8'h03, 8'h00);
      check_reg(8'h03, ID_VAL);
      check_reg(8'h05, 8'h00);
      host.write_reg(8'h00, 8'hf8);
      check_reg(8'h00, 8'h00);
      $display("test read-only done");

      host.write_frame(8'h02, 8'hd1);
      wait_clk(20);
      check({6'h0, ctrl.power_good_delay_select, ctrl.pulse_skip_power_saving}, 8'h01);
      host.stop();
      wait_clk(10);
      check({6'h0, ctrl.power_good_delay_select, ctrl.pulse_skip_power_saving}, 8'h03);
      check_reg(8'h02, 8'h11);
      host.addr_bits = 2'b00;
      host.write_reg(8'h02, 8'h2f);
      check({7'h0, host.acked}, 8'h00);
      host.addr_bits = ADR_BITS;
      check_reg(8'h02, 8'h11);
      $display("test commit and address done");

      for (int d = 0; d < 2; d++) begin
         if (d == 1) host.write_reg(8'h02, 8'h01);
         in_reg = 1'b0;
         wait_clk(10);
         check({7'h0, pg_out}, 8'h00);
         check_reg(8'h04, 8'h02);
         in_reg = 1'b1;
         wait_clk(8);
         check({7'h0, pg_out}, {7'h0, d[0]});
         wait_clk(40);
         check({7'h0, pg_out}, 8'h01);
      end
      $display("test power good done");

      host.write_reg(8'h01, 8'h3a);
      wait_clk(10);
      check({ctrl.regulator_enable, ctrl.ref_target_code}, {1'b0, DEF_CODE});
      for (int s = 1; s < 4; s++) begin
         p = n_pulses;
         host.write_reg(8'h04, {4'h3, 1'b0, s[1:0], 1'b0});
         wait_clk(10);
         check(8'(n_pulses - p), 8'h01);
         check({1'b0, ctrl.ref_target_code}, 8'h3a);
         check({5'h0, ctrl.discharge_enable, ctrl.slew_select}, {6'h1, s[1:0]});
         check_reg(8'h04, {4'h3, 1'b0, s[1:0], 1'b0});
      end
      ramp_done = 1'b1;
      wait_clk(10);
      check_reg(8'h04, 8'h3e);
      p = n_pulses;
      host.write_reg(8'h04, 8'h12);
      wait_clk(10);
      check(8'(n_pulses - p), 8'h01);
      check({1'b0, ctrl.ref_target_code}, {1'b0, DEF_CODE});
      check({7'h0, ctrl.discharge_enable}, 8'h01);
      host.write_reg(8'h01, 8'hba);
      wait_clk(10);
      check({ctrl.regulator_enable, 6'h0, ctrl.discharge_enable}, 8'h80);
      $display("test transition done");

      for (int i = 0; i < 3; i++) begin
         fault_event = brc_pkg::brc_fault_t'(3'(1 << i));
         wait_clk(6);
         fault_event = '0;
         check_reg(8'h00, 8'(1 << i));
         host.write_reg(8'h00, ~8'(1 << i));
         check_reg(8'h00, 8'(1 << i));
         host.write_reg(8'h00, 8'(1 << i));
         check_reg(8'h00, 8'h00);
      end
      $display("test fault flags done");
      give_verdict();
   end
endmodule
